// >>> ars_consts.svh
// Constants for the readback selector: offsets, codes, field positions.
// Assumes inclusion by bare name from design files.
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH
`define ARS_ADDR_W 8
`define ARS_OFF_DATA_SEL 8'h1c
`define ARS_SEL_REGS 16'h0000
`define ARS_SEL_AB 16'h0c00
`define ARS_SEL_CD 16'h0800
`define ARS_SMP_W 14
`define ARS_FIFO_DEPTH 16
`define ARS_PAD 2'h0
`endif

// >>> ars_pkg.sv
// Types shared by the readback selector files.
// Assumes ars_consts.svh is compiled with it.
`include "ars_consts.svh"
package ars_pkg;
   typedef enum logic [1:0] {
      ARS_MODE_REGS = 2'h0,
      ARS_MODE_AB = 2'h1,
      ARS_MODE_CD = 2'h3
   } ars_mode_type;
   typedef struct packed {
      logic [`ARS_SMP_W-1:0] hi;
      logic [`ARS_SMP_W-1:0] lo;
   } ars_pair_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`ARS_ADDR_W-1:0] addr;
      logic [15:0] wdata;
   } ars_req_type;
endpackage : ars_pkg

// >>> ars_fifo.sv
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock; clear empties it synchronously.
`timescale 1ns/100ps
`include "ars_consts.svh"
module ars_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = `ARS_FIFO_DEPTH
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic clear_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   wire push = in_valid_in && in_ready_out;
   wire pop = out_valid_out && out_ready_in;
   assign in_ready_out = (cnt_q != DEPTH[AW:0]) && !clear_in;
   assign out_valid_out = (cnt_q != '0) && !clear_in;
   assign out_data_out = mem_q[rp_q];
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_q[wp_q] <= in_data_in;
      end
   end
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (clear_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + AW'(1);
         if (pop) rp_q <= rp_q + AW'(1);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ars_fifo

// >>> ars_readback_select.sv
// Readback selector: data-select register steers host reads to register
// contents or packed channel-pair samples from per-pair sample FIFOs.
// Assumes the link gives one-cycle write/read strobes and that the ADC
// samples arrive already in this clock's domain from the upstream buffer.
`timescale 1ns/100ps
`include "ars_consts.svh"
// Function
// - Code zero resets FIFOs, selects register readback
// - FIFOs held in reset during register readback
// - Code 0x0C00 reads channel A/B FIFO
// - A/B word: pad, B, pad, A
// - Code 0x0800 reads channel C/D FIFO
// - C/D word: pad, D, pad, C
// - Samples passed raw, straight binary
// - Pair selection releases FIFOs from reset
// - Samples buffered before reaching control logic
module ars_readback_select #(
   parameter int DEPTH = `ARS_FIFO_DEPTH
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [`ARS_ADDR_W-1:0] host_addr_in,
   input wire logic [15:0] host_wdata_in,
   input wire logic [31:0] reg_rdata_in,
   output logic [31:0] host_rdata_out,
   output logic host_rvalid_out,
   output logic [1:0] mode_out,
   input wire logic ab_valid_in,
   input wire logic [`ARS_SMP_W-1:0] smp_a_in,
   input wire logic [`ARS_SMP_W-1:0] smp_b_in,
   output logic ab_ready_out,
   input wire logic cd_valid_in,
   input wire logic [`ARS_SMP_W-1:0] smp_c_in,
   input wire logic [`ARS_SMP_W-1:0] smp_d_in,
   output logic cd_ready_out
);
   localparam int PW = 2 * `ARS_SMP_W;
   ars_pkg::ars_req_type req;
   ars_pkg::ars_mode_type mode_q;
   ars_pkg::ars_mode_type mode_d;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic ab_rdy_q;
   logic cd_rdy_q;
   logic fifo_clr_q;
   wire ab_in_rdy;
   wire cd_in_rdy;
   wire ab_out_v;
   wire cd_out_v;
   ars_pkg::ars_pair_type ab_word;
   ars_pkg::ars_pair_type cd_word;
   ars_pkg::ars_pair_type ab_in;
   ars_pkg::ars_pair_type cd_in;

   assign req = '{wr: host_wr_in, rd: host_rd_in, addr: host_addr_in, wdata: host_wdata_in};
   wire sel_wr = req.wr && (req.addr == `ARS_OFF_DATA_SEL);
   // Any code outside the pair codes falls back to register readback
   assign mode_d = !sel_wr ? mode_q :
      (req.wdata == `ARS_SEL_AB) ? ars_pkg::ARS_MODE_AB :
      (req.wdata == `ARS_SEL_CD) ? ars_pkg::ARS_MODE_CD :
      ars_pkg::ARS_MODE_REGS;
   // FIFOs cleared while register readback holds; registered so the
   // clear follows the mode register exactly
   wire clr_d = (mode_d == ars_pkg::ARS_MODE_REGS);
   assign ab_in = '{hi: smp_b_in, lo: smp_a_in};
   assign cd_in = '{hi: smp_d_in, lo: smp_c_in};
   wire pop_ab = req.rd && (mode_q == ars_pkg::ARS_MODE_AB) && ab_out_v;
   wire pop_cd = req.rd && (mode_q == ars_pkg::ARS_MODE_CD) && cd_out_v;
   // Raw samples, zero-padded, no sign or offset change
   wire [31:0] ab_packed = {`ARS_PAD, ab_word.hi, `ARS_PAD, ab_word.lo};
   wire [31:0] cd_packed = {`ARS_PAD, cd_word.hi, `ARS_PAD, cd_word.lo};
   // An empty FIFO read returns zero rather than stalling the link
   wire [31:0] rdata_d = (mode_q == ars_pkg::ARS_MODE_AB) ? (ab_out_v ? ab_packed : '0) :
      (mode_q == ars_pkg::ARS_MODE_CD) ? (cd_out_v ? cd_packed : '0) : reg_rdata_in;

   // Samples buffered ahead of the readback logic
   ars_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) u_fifo_ab (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(fifo_clr_q),
      .in_valid_in(ab_valid_in),
      .in_ready_out(ab_in_rdy),
      .in_data_in(ab_in),
      .out_valid_out(ab_out_v),
      .out_ready_in(pop_ab),
      .out_data_out(ab_word)
   );
   ars_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) u_fifo_cd (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(fifo_clr_q),
      .in_valid_in(cd_valid_in),
      .in_ready_out(cd_in_rdy),
      .in_data_in(cd_in),
      .out_valid_out(cd_out_v),
      .out_ready_in(pop_cd),
      .out_data_out(cd_word)
   );

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_q <= ars_pkg::ARS_MODE_REGS;
         fifo_clr_q <= 1'b1;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         ab_rdy_q <= 1'b0;
         cd_rdy_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         fifo_clr_q <= clr_d;
         rvalid_q <= req.rd;
         if (req.rd) rdata_q <= rdata_d;
         // Registered ready lags one cycle; source must tolerate one extra push refusal
         ab_rdy_q <= ab_in_rdy && !clr_d;
         cd_rdy_q <= cd_in_rdy && !clr_d;
      end
   end

   assign host_rdata_out = rdata_q;
   assign host_rvalid_out = rvalid_q;
   assign mode_out = mode_q;
   assign ab_ready_out = ab_rdy_q;
   assign cd_ready_out = cd_rdy_q;

   property p_clr_regs;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_REGS) |-> fifo_clr_q;
   endproperty
   a_clr_regs: assert property (p_clr_regs) else $error("FIFO not held in reset");
   property p_zero_sel;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata == `ARS_SEL_REGS) |=> (mode_q == ars_pkg::ARS_MODE_REGS) && fifo_clr_q;
   endproperty
   a_zero_sel: assert property (p_zero_sel) else $error("Zero code not honoured");
   property p_ab_sel;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata == `ARS_SEL_AB) |=> (mode_q == ars_pkg::ARS_MODE_AB);
   endproperty
   a_ab_sel: assert property (p_ab_sel) else $error("A/B code not honoured");
   property p_cd_sel;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata == `ARS_SEL_CD) |=> (mode_q == ars_pkg::ARS_MODE_CD);
   endproperty
   a_cd_sel: assert property (p_cd_sel) else $error("C/D code not honoured");
   property p_ab_pack;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      pop_ab |=> (host_rdata_out == {`ARS_PAD, $past(ab_word.hi), `ARS_PAD, $past(ab_word.lo)});
   endproperty
   a_ab_pack: assert property (p_ab_pack) else $error("A/B word packed wrong");
   property p_cd_pack;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      pop_cd |=> (host_rdata_out ==
         {`ARS_PAD, $past(cd_word.hi), `ARS_PAD, $past(cd_word.lo)});
   endproperty
   a_cd_pack: assert property (p_cd_pack) else $error("C/D word packed wrong");
   property p_release;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q != ars_pkg::ARS_MODE_REGS) |-> !fifo_clr_q;
   endproperty
   a_release: assert property (p_release) else $error("FIFO not released");
   property p_undef;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata != `ARS_SEL_AB && req.wdata != `ARS_SEL_CD)
         |=> (mode_q == ars_pkg::ARS_MODE_REGS) ##1 fifo_clr_q;
   endproperty
   a_undef: assert property (p_undef) else $error("Unknown code not readback");
   property p_reg_read;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (req.rd && mode_q == ars_pkg::ARS_MODE_REGS) |=> (host_rdata_out == $past(reg_rdata_in));
   endproperty
   a_reg_read: assert property (p_reg_read) else $error("Register readback wrong");
   // Readies and FIFO outputs stay quiet while register readback holds
   property p_ab_rdy_regs;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_REGS) |-> !ab_ready_out;
   endproperty
   a_ab_rdy_regs: assert property (p_ab_rdy_regs) else $error("A/B ready in regs");
   property p_cd_rdy_regs;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_REGS) |-> !cd_ready_out;
   endproperty
   a_cd_rdy_regs: assert property (p_cd_rdy_regs) else $error("C/D ready in regs");
   property p_ab_empty_regs;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_REGS) |-> !ab_out_v;
   endproperty
   a_ab_empty_regs: assert property (p_ab_empty_regs) else $error("A/B data in regs");
   property p_cd_empty_regs;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_REGS) |-> !cd_out_v;
   endproperty
   a_cd_empty_regs: assert property (p_cd_empty_regs) else $error("C/D data in regs");
   // A fresh release must never expose samples kept from before the clear
   property p_ab_fresh;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      $fell(fifo_clr_q) |-> !ab_out_v;
   endproperty
   a_ab_fresh: assert property (p_ab_fresh) else $error("A/B stale data");
   property p_cd_fresh;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      $fell(fifo_clr_q) |-> !cd_out_v;
   endproperty
   a_cd_fresh: assert property (p_cd_fresh) else $error("C/D stale data");
   property p_zero_empty;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata == `ARS_SEL_REGS) |=> !ab_out_v && !cd_out_v;
   endproperty
   a_zero_empty: assert property (p_zero_empty) else $error("Zero code kept data");
   property p_odd_rdy;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata != `ARS_SEL_AB && req.wdata != `ARS_SEL_CD)
         |=> !ab_ready_out && !cd_ready_out;
   endproperty
   a_odd_rdy: assert property (p_odd_rdy) else $error("Ready after odd code");
   property p_mode_legal;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      mode_q inside {ars_pkg::ARS_MODE_REGS, ars_pkg::ARS_MODE_AB, ars_pkg::ARS_MODE_CD};
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("Illegal mode");
   // Pair selection frees the FIFOs at once and raises both readies next
   property p_ab_release;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata == `ARS_SEL_AB) |=> !fifo_clr_q;
   endproperty
   a_ab_release: assert property (p_ab_release) else $error("A/B not released");
   property p_cd_release;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (sel_wr && req.wdata == `ARS_SEL_CD) |=> !fifo_clr_q;
   endproperty
   a_cd_release: assert property (p_cd_release) else $error("C/D not released");
   property p_rdy_rise;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      ($fell(fifo_clr_q) && !sel_wr) |=> ab_ready_out && cd_ready_out;
   endproperty
   a_rdy_rise: assert property (p_rdy_rise) else $error("Ready not raised");
   property p_ab_rdy_full;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !ab_in_rdy |=> !ab_ready_out;
   endproperty
   a_ab_rdy_full: assert property (p_ab_rdy_full) else $error("A/B ready when full");
   property p_cd_rdy_full;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !cd_in_rdy |=> !cd_ready_out;
   endproperty
   a_cd_rdy_full: assert property (p_cd_rdy_full) else $error("C/D ready when full");
   // Switching between pairs keeps the other pair's samples
   property p_ab_keep;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_CD && ab_out_v && !sel_wr) |=> ab_out_v;
   endproperty
   a_ab_keep: assert property (p_ab_keep) else $error("A/B data lost");
   property p_cd_keep;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (mode_q == ars_pkg::ARS_MODE_AB && cd_out_v && !sel_wr) |=> cd_out_v;
   endproperty
   a_cd_keep: assert property (p_cd_keep) else $error("C/D data lost");
   // Read answers: one-cycle valid, data held between reads
   property p_rvalid;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      host_rd_in |=> host_rvalid_out;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("Read not answered");
   property p_rvalid_low;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !host_rd_in |=> !host_rvalid_out;
   endproperty
   a_rvalid_low: assert property (p_rvalid_low) else $error("Extra rvalid");
   property p_rdata_hold;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !host_rd_in |=> $stable(host_rdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved");
   property p_mode_hold;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !sel_wr |=> $stable(mode_out);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("Mode moved");
   property p_other_addr;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (host_wr_in && host_addr_in != `ARS_OFF_DATA_SEL) |=> $stable(mode_out);
   endproperty
   a_other_addr: assert property (p_other_addr) else $error("Foreign write hit");
   property p_ab_empty_read;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (host_rd_in && mode_q == ars_pkg::ARS_MODE_AB && !ab_out_v) |=> (host_rdata_out == '0);
   endproperty
   a_ab_empty_read: assert property (p_ab_empty_read) else $error("A/B empty read");
   property p_cd_empty_read;
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      (host_rd_in && mode_q == ars_pkg::ARS_MODE_CD && !cd_out_v) |=> (host_rdata_out == '0);
   endproperty
   a_cd_empty_read: assert property (p_cd_empty_read) else $error("C/D empty read");
   // Checked on the first edge after release, so no disable here
   property p_rst_release;
      @(posedge sys_clk_in)
      $fell(sys_rst_in) |-> (mode_q == ars_pkg::ARS_MODE_REGS) && fifo_clr_q
         && !ab_ready_out && !cd_ready_out;
   endproperty
   a_rst_release: assert property (p_rst_release) else $error("Reset state wrong");
endmodule : ars_readback_select

// >>> ars_host_model.sv
// Host side of the register link: one-cycle write and read strobes.
// Assumes the bench calls its tasks from a falling edge of the clock.
`timescale 1ns/100ps
module ars_host_model (
   input wire logic clk_in,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] addr_out,
   output logic [15:0] wdata_out
);
   initial {wr_out, rd_out, addr_out, wdata_out} = '0;
   // Data is inverted once released so a stale word never looks valid
   task put(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_in);
      {wr_out, addr_out, wdata_out} = {1'b1, a, d};
      @(negedge clk_in);
      {wr_out, wdata_out} = {1'b0, ~d};
   endtask : put
   task get;
      @(negedge clk_in);
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
   endtask : get
endmodule : ars_host_model

// >>> ars_readback_select_tb.sv
// Self-checking bench for the readback selector against a queue model.
// Assumes the host model drives the link; sample pairs are fed here.
`timescale 1ns/100ps
`include "ars_consts.svh"
module ars_readback_select_tb;
   localparam int DEPTH = 16;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [31:0] reg_rdata, host_rdata;
   logic host_wr, host_rd, host_rvalid, ab_ready, cd_ready;
   logic ab_valid = 1'b0, cd_valid = 1'b0;
   logic [7:0] host_addr;
   logic [15:0] host_wdata;
   logic [1:0] mode;
   logic [13:0] smp_a = '0, smp_b = '0, smp_c = '0, smp_d = '0;
   int mismatches = 0, cmp_count = 0, mode_m = 0;
   logic [31:0] q_ab[$], q_cd[$];
   always #50 sys_clk_in = ~sys_clk_in;
   ars_host_model host (.clk_in(sys_clk_in), .wr_out(host_wr), .rd_out(host_rd),
      .addr_out(host_addr), .wdata_out(host_wdata));
   ars_readback_select #(.DEPTH(DEPTH)) uut (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .host_wr_in(host_wr), .host_rd_in(host_rd),
      .host_addr_in(host_addr), .host_wdata_in(host_wdata), .reg_rdata_in(reg_rdata),
      .host_rdata_out(host_rdata), .host_rvalid_out(host_rvalid), .mode_out(mode),
      .ab_valid_in(ab_valid), .smp_a_in(smp_a), .smp_b_in(smp_b), .ab_ready_out(ab_ready),
      .cd_valid_in(cd_valid), .smp_c_in(smp_c), .smp_d_in(smp_d), .cd_ready_out(cd_ready));
   always @(posedge sys_clk_in) begin
      if (ab_valid && ab_ready) q_ab.push_back({2'h0, smp_b, 2'h0, smp_a});
      if (cd_valid && cd_ready) q_cd.push_back({2'h0, smp_d, 2'h0, smp_c});
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task sel(input logic [15:0] code);
      host.put(`ARS_OFF_DATA_SEL, code);
      mode_m = (code == `ARS_SEL_AB) ? 1 : (code == `ARS_SEL_CD) ? 3 : 0;
      if (mode_m == 0) q_ab.delete();
      if (mode_m == 0) q_cd.delete();
      chk(32'(mode), 32'(mode_m));
   endtask : sel
   task rd_chk;
      logic [31:0] exp;
      reg_rdata = $urandom;
      host.get();
      exp = 32'h0;
      if (mode_m == 0) exp = reg_rdata;
      else if (mode_m == 1 && q_ab.size() > 0) exp = q_ab.pop_front();
      else if (mode_m == 3 && q_cd.size() > 0) exp = q_cd.pop_front();
      chk({31'h0, host_rvalid}, 32'h1);
      chk(host_rdata, exp);
   endtask : rd_chk
   // Stops at exactly n pushes since ready lags a full FIFO by a cycle
   task push(input bit cd, input int n);
      int k;
      k = 0;
      while (k < n) begin
         @(negedge sys_clk_in);
         {smp_a, smp_b, smp_c, smp_d} = 56'({$urandom, $urandom});
         ab_valid = !cd && ab_ready;
         cd_valid = cd && cd_ready;
         if (ab_valid || cd_valid) k++;
      end
      @(negedge sys_clk_in);
      {ab_valid, cd_valid} = 2'h0;
   endtask : push
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   initial begin
      #1000000;
      mismatches++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h743c287b));
      reg_rdata = '0;
      repeat (20) @(negedge sys_clk_in);
      sys_rst_in = 1'b0;
      chk({28'h0, mode, ab_ready, cd_ready}, 32'h0);
      sel(`ARS_SEL_REGS);
      rd_chk();
      $display("test register readback done");
      sel(`ARS_SEL_AB);
      push(0, DEPTH);
      repeat (2) @(negedge sys_clk_in);
      chk({31'h0, ab_ready}, 32'h0);
      repeat (DEPTH + 1) rd_chk();
      push(1, 5);
      $display("test pair a b done");
      sel(`ARS_SEL_CD);
      repeat (3) rd_chk();
      push(0, 2);
      $display("test pair c d done");
      sel(`ARS_SEL_REGS);
      repeat (3) @(negedge sys_clk_in);
      chk({31'h0, cd_ready}, 32'h0);
      repeat (2) rd_chk();
      host.put(8'h20, `ARS_SEL_CD);
      chk(32'(mode), 32'h0);
      sel(`ARS_SEL_CD);
      rd_chk();
      sel(16'($urandom) | 16'h0001);
      rd_chk();
      $display("test clear and odd codes done");
      end_of_test();
   end
endmodule : ars_readback_select_tb
